/* File: design/pecd_params.svh */
// offsets, field positions and reset values of the edge change block
`ifndef PECD_PARAMS_SVH
`define PECD_PARAMS_SVH
// printed register indices (byte address is four times the index)
`define PECD_IDX_A_RISE   16'h1F3D
`define PECD_IDX_A_FALL   16'h1F3E
`define PECD_IDX_A_FLAGS  16'h1F3F
`define PECD_IDX_B_RISE   16'h1F48
`define PECD_IDX_B_FALL   16'h1F49
`define PECD_IDX_B_FLAGS  16'h1F4A
`define PECD_IDX_C_RISE   16'h1F53
`define PECD_IDX_C_FALL   16'h1F54
`define PECD_IDX_C_FLAGS  16'h1F55
`define PECD_IDX_E_RISE   16'h1F69
`define PECD_IDX_E_FALL   16'h1F6A
`define PECD_IDX_E_FLAGS  16'h1F6B
// interrupt registers of our own
`define PECD_IDX_IRQ_STAT 16'h1F70
`define PECD_IDX_IRQ_EN   16'h1F71
`define PECD_IDX_IRQ_CLR  16'h1F72
// field layout and reset values
`define PECD_E_PIN_BIT    3
`define PECD_E_MASK       8'h08
`define PECD_REG_RESET    8'h00
`define PECD_IRQ_CHANGE   0
`endif

/* File: design/pecd_pkg.sv */
// types shared by the edge change block
package pecd_pkg;
  typedef logic [7:0]  pecd_byte_t;
  typedef logic [15:0] pecd_index_t;
  typedef enum logic [1:0] {
    PECD_PH_IDLE  = 2'b00,
    PECD_PH_READ  = 2'b01,
    PECD_PH_WRITE = 2'b10
  } pecd_phase_e;
endpackage

/* File: design/pecd_port_detect.sv */
// per-pin edge detector and change flags for one eight-bit port
`timescale 1ns/1ps
`include "pecd_params.svh"
module pecd_port_detect
  import pecd_pkg::*;
(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // pin levels and arming
  input  wire pecd_byte_t pins,
  input  wire pecd_byte_t pin_valid,
  input  wire pecd_byte_t rise_enable,
  input  wire pecd_byte_t fall_enable,
  // software write of the flags
  input  wire logic       flag_write,
  input  wire pecd_byte_t flag_wdata,
  // flags and edge events
  output pecd_byte_t      change_flags,
  output logic            edge_seen
);
  pecd_byte_t prev_pins;
  pecd_byte_t next_prev_pins;
  pecd_byte_t next_flags;
  pecd_byte_t set_pulse;

  // one set pulse per armed edge, per pin
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      assign set_pulse[g] = pin_valid[g] & (
        (rise_enable[g] & pins[g] & ~prev_pins[g]) |
        (fall_enable[g] & ~pins[g] & prev_pins[g]));
    end
  endgenerate

  // next sample and flag values; set beats a clearing write
  always_comb begin
    next_prev_pins = pins;
    next_flags     = change_flags;
    if (flag_write) begin
      next_flags = flag_wdata & pin_valid;
    end
    next_flags = next_flags | set_pulse;
  end

  // register pins and flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_pins    <= `PECD_REG_RESET;
      change_flags <= `PECD_REG_RESET;
    end else begin
      prev_pins    <= next_prev_pins;
      change_flags <= next_flags;
    end
  end

  assign edge_seen = |set_pulse;
endmodule // pecd_port_detect

/* File: design/pecd_top.sv */
// edge change detection for ports a, b, c and pin e3 with ahb-lite slave
`timescale 1ns/1ps
`include "pecd_params.svh"
module pecd_top
  import pecd_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // pins and configuration
  input  wire logic [7:0]  port_a_pins,
  input  wire logic [7:0]  port_b_pins,
  input  wire logic [7:0]  port_c_pins,
  input  wire logic        port_e_bit3_pin,
  input  wire logic        master_clear_pin_enable,
  input  wire logic        low_voltage_program_enable,
  input  wire logic        change_irq_enable,
  // interrupt outputs
  output logic             change_irq_summary_flag,
  output logic             change_irq,
  output logic             irq
);
  // software enable registers and change flags
  pecd_byte_t  port_a_rise_enable;
  pecd_byte_t  port_a_fall_enable;
  pecd_byte_t  port_b_rise_enable;
  pecd_byte_t  port_b_fall_enable;
  pecd_byte_t  port_c_rise_enable;
  pecd_byte_t  port_c_fall_enable;
  pecd_byte_t  port_e_rise_enable;
  pecd_byte_t  port_e_fall_enable;
  pecd_byte_t  port_a_change_flags;
  pecd_byte_t  port_b_change_flags;
  pecd_byte_t  port_c_change_flags;
  pecd_byte_t  port_e_change_flags;
  pecd_byte_t  irq_status;
  pecd_byte_t  irq_enable;
  // next values of the registers
  pecd_byte_t  next_a_rise;
  pecd_byte_t  next_a_fall;
  pecd_byte_t  next_b_rise;
  pecd_byte_t  next_b_fall;
  pecd_byte_t  next_c_rise;
  pecd_byte_t  next_c_fall;
  pecd_byte_t  next_e_rise;
  pecd_byte_t  next_e_fall;
  pecd_byte_t  next_irq_status;
  pecd_byte_t  next_irq_enable;
  // bus phase tracking
  pecd_phase_e phase;
  pecd_phase_e next_phase;
  pecd_index_t dp_index;
  pecd_index_t next_dp_index;
  logic [31:0] next_hrdata;
  logic        addr_taken;
  logic        wr_now;
  // detector wiring
  logic [3:0]  edge_seen;
  logic [3:0]  flag_write;
  logic        e3_valid;
  pecd_byte_t  wbyte;
  pecd_byte_t  e_pins;
  pecd_byte_t  e_valid;

  // bus side: one-cycle data phase, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // transfer decode; write data lands in the data phase
  assign addr_taken = hsel && hready && htrans[1];
  assign wbyte      = hwdata[7:0];
  assign wr_now     = (phase == PECD_PH_WRITE);

  // port e bit 3 exists only when the pin is a port pin
  assign e3_valid = ~(master_clear_pin_enable |
                      low_voltage_program_enable);
  assign e_pins   = {4'h0, port_e_bit3_pin, 3'h0};
  assign e_valid  = e3_valid ? `PECD_E_MASK : 8'h00;

  // flag writes land in the data phase
  assign flag_write[0] = wr_now && dp_index == `PECD_IDX_A_FLAGS;
  assign flag_write[1] = wr_now && dp_index == `PECD_IDX_B_FLAGS;
  assign flag_write[2] = wr_now && dp_index == `PECD_IDX_C_FLAGS;
  assign flag_write[3] = wr_now && dp_index == `PECD_IDX_E_FLAGS;

  // per-port detectors
  pecd_port_detect u_port_a (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .pins         (port_a_pins),
    .pin_valid    (8'hFF),
    .rise_enable  (port_a_rise_enable),
    .fall_enable  (port_a_fall_enable),
    .flag_write   (flag_write[0]),
    .flag_wdata   (wbyte),
    .change_flags (port_a_change_flags),
    .edge_seen    (edge_seen[0])
  );

  pecd_port_detect u_port_b (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .pins         (port_b_pins),
    .pin_valid    (8'hFF),
    .rise_enable  (port_b_rise_enable),
    .fall_enable  (port_b_fall_enable),
    .flag_write   (flag_write[1]),
    .flag_wdata   (wbyte),
    .change_flags (port_b_change_flags),
    .edge_seen    (edge_seen[1])
  );

  pecd_port_detect u_port_c (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .pins         (port_c_pins),
    .pin_valid    (8'hFF),
    .rise_enable  (port_c_rise_enable),
    .fall_enable  (port_c_fall_enable),
    .flag_write   (flag_write[2]),
    .flag_wdata   (wbyte),
    .change_flags (port_c_change_flags),
    .edge_seen    (edge_seen[2])
  );

  pecd_port_detect u_port_e (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .pins         (e_pins),
    .pin_valid    (e_valid),
    .rise_enable  (port_e_rise_enable),
    .fall_enable  (port_e_fall_enable),
    .flag_write   (flag_write[3]),
    .flag_wdata   (wbyte),
    .change_flags (port_e_change_flags),
    .edge_seen    (edge_seen[3])
  );

  // summary flag: or of every implemented change flag
  assign change_irq_summary_flag = |{port_a_change_flags,
                                     port_b_change_flags,
                                     port_c_change_flags,
                                     port_e_change_flags};

  // core request, masked by the enable pin; flags still set
  assign change_irq = change_irq_summary_flag &
                      change_irq_enable;
  assign irq = |(irq_status & irq_enable);

  // address phase capture
  always_comb begin
    next_phase    = PECD_PH_IDLE;
    next_dp_index = dp_index;
    if (addr_taken) begin
      next_phase    = hwrite ? PECD_PH_WRITE : PECD_PH_READ;
      next_dp_index = haddr[17:2];
    end
  end

  // enable register updates
  always_comb begin
    next_a_rise     = port_a_rise_enable;
    next_a_fall     = port_a_fall_enable;
    next_b_rise     = port_b_rise_enable;
    next_b_fall     = port_b_fall_enable;
    next_c_rise     = port_c_rise_enable;
    next_c_fall     = port_c_fall_enable;
    next_e_rise     = port_e_rise_enable;
    next_e_fall     = port_e_fall_enable;
    if (wr_now) begin
      case (dp_index)
        `PECD_IDX_A_RISE:   next_a_rise = wbyte;
        `PECD_IDX_A_FALL:   next_a_fall = wbyte;
        `PECD_IDX_B_RISE:   next_b_rise = wbyte;
        `PECD_IDX_B_FALL:   next_b_fall = wbyte;
        `PECD_IDX_C_RISE:   next_c_rise = wbyte;
        `PECD_IDX_C_FALL:   next_c_fall = wbyte;
        `PECD_IDX_E_RISE:   next_e_rise = wbyte & `PECD_E_MASK;
        `PECD_IDX_E_FALL:   next_e_fall = wbyte & `PECD_E_MASK;
        default:            next_a_rise = port_a_rise_enable;
      endcase
    end
  end

  // interrupt enable and clear writes
  always_comb begin
    next_irq_enable = irq_enable;
    next_irq_status = irq_status;
    if (wr_now) begin
      case (dp_index)
        `PECD_IDX_IRQ_EN:   next_irq_enable = wbyte;
        `PECD_IDX_IRQ_CLR:  next_irq_status = irq_status & ~wbyte;
        default:            next_irq_enable = irq_enable;
      endcase
    end
    // edge event sticks, set wins over clear
    next_irq_status[`PECD_IRQ_CHANGE] =
      next_irq_status[`PECD_IRQ_CHANGE] | (|edge_seen);
  end

  // read data mux, unmapped reads zero
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (next_phase == PECD_PH_READ) begin
      case (next_dp_index)
        `PECD_IDX_A_RISE:   next_hrdata[7:0] = port_a_rise_enable;
        `PECD_IDX_A_FALL:   next_hrdata[7:0] = port_a_fall_enable;
        `PECD_IDX_A_FLAGS:  next_hrdata[7:0] = port_a_change_flags;
        `PECD_IDX_B_RISE:   next_hrdata[7:0] = port_b_rise_enable;
        `PECD_IDX_B_FALL:   next_hrdata[7:0] = port_b_fall_enable;
        `PECD_IDX_B_FLAGS:  next_hrdata[7:0] = port_b_change_flags;
        `PECD_IDX_C_RISE:   next_hrdata[7:0] = port_c_rise_enable;
        `PECD_IDX_C_FALL:   next_hrdata[7:0] = port_c_fall_enable;
        `PECD_IDX_C_FLAGS:  next_hrdata[7:0] = port_c_change_flags;
        `PECD_IDX_E_RISE:   next_hrdata[7:0] = port_e_rise_enable;
        `PECD_IDX_E_FALL:   next_hrdata[7:0] = port_e_fall_enable;
        `PECD_IDX_E_FLAGS:  next_hrdata[7:0] = port_e_change_flags;
        `PECD_IDX_IRQ_STAT: next_hrdata[7:0] = irq_status;
        `PECD_IDX_IRQ_EN:   next_hrdata[7:0] = irq_enable;
        default:            next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  // bus phase registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase    <= PECD_PH_IDLE;
      dp_index <= 16'h0000;
    end else begin
      phase    <= next_phase;
      dp_index <= next_dp_index;
    end
  end

  // read data, standing for the data phase only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= next_hrdata;
    end
  end

  // edge enable registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_a_rise_enable <= `PECD_REG_RESET;
      port_a_fall_enable <= `PECD_REG_RESET;
      port_b_rise_enable <= `PECD_REG_RESET;
      port_b_fall_enable <= `PECD_REG_RESET;
      port_c_rise_enable <= `PECD_REG_RESET;
      port_c_fall_enable <= `PECD_REG_RESET;
      port_e_rise_enable <= `PECD_REG_RESET;
      port_e_fall_enable <= `PECD_REG_RESET;
    end else begin
      port_a_rise_enable <= next_a_rise;
      port_a_fall_enable <= next_a_fall;
      port_b_rise_enable <= next_b_rise;
      port_b_fall_enable <= next_b_fall;
      port_c_rise_enable <= next_c_rise;
      port_c_fall_enable <= next_c_fall;
      port_e_rise_enable <= next_e_rise;
      port_e_fall_enable <= next_e_fall;
    end
  end

  // interrupt status and enable registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= `PECD_REG_RESET;
      irq_enable <= `PECD_REG_RESET;
    end else begin
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
    end
  end
endmodule // pecd_top

/* File: verification/pecd_checker.sv */
// port assertions for the edge change block
`timescale 1ns/1ps
module pecd_checker
  import pecd_pkg::*;
(
  // clock, reset and bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // pins and configuration
  input wire logic [7:0]  port_a_pins,
  input wire logic [7:0]  port_b_pins,
  input wire logic [7:0]  port_c_pins,
  input wire logic        port_e_bit3_pin,
  input wire logic        master_clear_pin_enable,
  input wire logic        low_voltage_program_enable,
  input wire logic        change_irq_enable,
  // interrupt outputs
  input wire logic        change_irq_summary_flag,
  input wire logic        change_irq,
  input wire logic        irq
);
  // previous pin samples and taken transfers
  logic [24:0] pq;
  logic        wq, rq, uq;
  wire  [24:0] pn = {port_a_pins, port_b_pins, port_c_pins, port_e_bit3_pin};
  wire  [15:0] ix = haddr[17:2];
  wire         tk = hsel && hready && htrans[1];
  wire         eg = pn[24:1] != pq[24:1];
  wire         e3g = pn[0] != pq[0] && !master_clear_pin_enable &&
                     !low_voltage_program_enable;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) {pq, wq, rq, uq} <= '0;
    else {pq, wq, rq, uq} <= {pn, tk && hwrite,
      tk && !hwrite && ix inside {[16'h1F69:16'h1F6B]},
      tk && !hwrite && ix inside {[16'h1F40:16'h1F47]}};
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  reset_clear_a: assert property (!$past(hresetn) |->
    !change_irq_summary_flag && !irq && hrdata == 32'h0)
    else $error("outputs not clear after reset");
  data_width_a: assert property (hrdata[31:8] == 24'h0)
    else $error("read data above bit 7 set");
  e_bits_a: assert property (rq |-> (hrdata[7:0] & 8'hF7) == 8'h0)
    else $error("port e read shows an unimplemented bit");
  reserved_zero_a: assert property (uq |-> hrdata == 32'h0)
    else $error("reserved word reads nonzero");
  set_cause_a: assert property (
    $rose(change_irq_summary_flag) |-> $past(wq) || $past(eg) || $past(e3g))
    else $error("summary rose without an edge or write");
  clear_cause_a: assert property (
    $fell(change_irq_summary_flag) |-> $past(wq))
    else $error("summary fell without a write");
  irq_mask_a: assert property (
    change_irq == (change_irq_summary_flag && change_irq_enable))
    else $error("change interrupt not summary and enable");
  irq_cause_a: assert property (
    $rose(irq) |-> $past(wq) || $past(eg) || $past(e3g))
    else $error("interrupt rose without an edge or write");
endmodule // pecd_checker

bind pecd_top pecd_checker u_pecd_checker (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hrdata, .port_a_pins, .port_b_pins,
  .port_c_pins, .port_e_bit3_pin, .master_clear_pin_enable,
  .low_voltage_program_enable, .change_irq_enable,
  .change_irq_summary_flag, .change_irq, .irq);

/* File: verification/pin_edge_change_detect_bench.sv */
// self-checking bench for the edge change block
`timescale 1ns/1ps
module pin_edge_change_detect_bench
  import pecd_pkg::*;
;
  // bus, pins and reference model
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        e3 = 1'b0, mcl = 1'b0, lowv = 1'b0, cie = 1'b0;
  logic        rdp = 1'b0, efl = 1'b0, hready, sum, cirq, irq, hresp;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  pecd_byte_t  pa = 8'h00, pb = 8'h00, pc = 8'h00, tog = 8'h00, v;
  pecd_byte_t  rm [4], fm [4], fl [3] = '{3{8'h00}}, pm [3] = '{3{8'h00}};
  pecd_byte_t  exq [$];
  pecd_index_t bs [4] = '{16'h1F3D, 16'h1F48, 16'h1F53, 16'h1F69};
  int          seed = 32'h3941, num_errors = 0, comparisons = 0, cyc = 0;
  pecd_top u_pecd_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .port_a_pins(pa), .port_b_pins(pb), .port_c_pins(pc),
    .port_e_bit3_pin(e3), .master_clear_pin_enable(mcl),
    .low_voltage_program_enable(lowv), .change_irq_enable(cie),
    .change_irq_summary_flag(sum), .change_irq(cirq), .irq(irq));
  // clock, cycle ceiling and read data monitor
  always #20 hclk = ~hclk;
  always @(posedge hclk)
    if (++cyc == 8000) begin
      num_errors++;
      stop_test;
    end
  always @(posedge hclk)
    if (rdp === 1'b1) begin
      check(hrdata, {24'h0, exq.pop_front()});
      check(hresp, 1'b0);
    end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t: got %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one single transfer; a read notes its expected byte
  task automatic bus(pecd_index_t i, logic w, pecd_byte_t d);
    if (!w) exq.push_back(d);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 14'h0, i, 2'h0};
    do @(posedge hclk); while (hready !== 1'b1);
    {hsel, htrans, hwdata, rdp, pa} <= {27'h0, d, !w, pa ^ tog};
    do @(posedge hclk); while (hready !== 1'b1);
    rdp <= 1'b0;
  endtask
  task automatic rd(pecd_index_t i, pecd_byte_t e); bus(i, 1'b0, e); endtask
  task automatic wr(pecd_index_t i, pecd_byte_t d); bus(i, 1'b1, d); endtask
  // random pin activity, flags worked out alongside; e3 ends low
  task automatic walk(int n);
    logic ne;
    for (int k = 0; k < n; k++) begin
      @(posedge hclk);
      for (int p = 0; p < 3; p++) begin
        v = 8'($random(seed));
        fl[p] |= (v & ~pm[p] & rm[p]) | (~v & pm[p] & fm[p]);
        pm[p] = v;
      end
      ne = (k < n - 1) && 1'($random(seed));
      if (!mcl && !lowv) efl |= (ne & ~e3 & rm[3][3]) | (~ne & e3 & fm[3][3]);
      {pa, pb, pc, e3} <= {pm[0], pm[1], pm[2], ne};
    end
  endtask
  // flag bytes and summary against the model, then clear
  task automatic verify;
    logic s;
    for (int p = 0; p < 3; p++)
      rd(bs[p] + 16'h2, fl[p]);
    rd(16'h1F6B, {4'h0, efl, 3'h0});
    s = |{fl[0], fl[1], fl[2], efl};
    @(negedge hclk);
    check(sum, s);
    check(cirq, s & cie);
    for (int p = 0; p < 4; p++)
      wr(bs[p] + 16'h2, 8'h00);
    fl = '{3{8'h00}};
    efl = 1'b0;
  endtask
  // reset values, read back, walks per mode, interrupt, clear race
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    for (int p = 0; p < 4; p++)
      for (int j = 0; j < 3; j++)
        rd(bs[p] + 16'(j), 8'h00);
    rd(16'h1F40, 8'h00);
    for (int p = 0; p < 4; p++)
      for (int j = 0; j < 2; j++) begin
        v = 8'($random(seed)) | (p == 3 ? 8'h08 : 8'h00);
        wr(bs[p] + 16'(j), v);
        if (p == 3) v &= 8'h08;
        rd(bs[p] + 16'(j), v);
        if (j == 0) rm[p] = v;
        else fm[p] = v;
      end
    for (int k = 0; k < 3; k++) begin
      {mcl, lowv, cie} <= {k == 1, k == 2, k != 0};
      walk(40);
      verify;
    end
    rd(16'h1F70, 8'h01);
    check(irq, 1'b0);
    wr(16'h1F71, 8'h01);
    @(negedge hclk);
    check(irq, 1'b1);
    wr(16'h1F72, 8'h01);
    rd(16'h1F70, 8'h00);
    check(irq, 1'b0);
    wr(16'h1F3D, 8'hFF);
    wr(16'h1F3E, 8'hFF);
    tog = 8'h01;
    wr(16'h1F3F, 8'h00);
    tog = 8'h00;
    rd(16'h1F3F, 8'h01);
    @(negedge hclk);
    check(irq, 1'b1);
    stop_test;
  end
endmodule // pin_edge_change_detect_bench
